// ---- logic/rampc_base_reg.sv ----
// One RAM base register holding only the writable 1 KB granular bits.
`timescale 1ns/1ns
`include "rampc_defs.svh"
`default_nettype none
module rampc_base_reg (
  input  wire logic                  mclk,
  input  wire logic                  reset,
  input  wire logic                  wr_en,
  input  wire logic [31:0]           wr_data,
  output var  rampc_pkg::rampc_base_t base_q,
  output logic [31:0]                rd_word
);
  import rampc_pkg::*;

  rampc_base_t base_ff;

  always_ff @(posedge mclk) begin
    if (reset) begin
      base_ff <= `RAMPC_BASE_RST;
    end else if (wr_en) begin
      base_ff <= wr_data[`RAMPC_BASE_HI:`RAMPC_BASE_LO];
    end
  end

  assign base_q  = base_ff;
  assign rd_word = {16'h0000, base_ff, 10'h000};
endmodule
`default_nettype wire

// ---- logic/rampc_classify.sv ----
// Maps a RAM offset onto its partition region.
`timescale 1ns/1ns
`default_nettype none
module rampc_classify (
  input  wire logic [31:0]            offset,
  input  wire logic [31:0]            kpb,
  input  wire logic [31:0]            udb,
  input  wire logic [31:0]            upb,
  input  wire logic [31:0]            ram_size,
  output var  rampc_pkg::rampc_region_e region,
  output logic                        in_range
);
  import rampc_pkg::*;

  always_comb begin
    in_range = (offset < ram_size);
    if (kpb != 32'h00000000 && offset >= kpb && (udb == 32'h00000000 || offset < udb)
        && !(upb != 32'h00000000 && offset >= upb)) begin
      region = rampc_kprog;
    end else if (udb != 32'h00000000 && offset >= udb && (upb == 32'h00000000 || offset < upb)) begin
      region = rampc_udata;
    end else if (upb != 32'h00000000 && offset >= upb) begin
      region = rampc_uprog;
    end else begin
      region = rampc_kdata;
    end
  end
endmodule
`default_nettype wire

// ---- logic/rampc_defs.svh ----
// Register offsets, field positions, reset values and size codes of the RAM partition block.
`ifndef RAMPC_DEFS_SVH
`define RAMPC_DEFS_SVH
`define RAMPC_OFS_KPB        4'h0
`define RAMPC_OFS_UDB        4'h4
`define RAMPC_OFS_UPB        4'h8
`define RAMPC_OFS_SIZE       4'hC
`define RAMPC_BASE_HI        15
`define RAMPC_BASE_LO        10
`define RAMPC_BASE_RST       6'h00
`define RAMPC_SIZE_4K        32'h00001000
`define RAMPC_SIZE_8K        32'h00002000
`define RAMPC_SIZE_16K       32'h00004000
`define RAMPC_SIZE_32K       32'h00008000
`define RAMPC_UNMAPPED_RD    32'h00000000
`endif

// ---- logic/rampc_pkg.sv ----
// Types shared by the RAM partition block.
`default_nettype none
package rampc_pkg;
  typedef logic [5:0] rampc_base_t;
  typedef enum logic [1:0] {
    rampc_kdata = 2'b00,
    rampc_kprog = 2'b01,
    rampc_udata = 2'b10,
    rampc_uprog = 2'b11
  } rampc_region_e;
  typedef enum logic [0:0] {
    rampc_idle = 1'b0,
    rampc_done = 1'b1
  } rampc_bus_e;
endpackage
`default_nettype wire

// ---- logic/rampc_top.sv ----
// Top of the RAM partition block with its Avalon-MM register slave.
`timescale 1ns/1ns
`include "rampc_defs.svh"
`default_nettype none
module rampc_top #(
  parameter logic [31:0] RAM_BYTES = `RAMPC_SIZE_32K
) (
  input  wire logic                   mclk,
  input  wire logic                   reset,
  input  wire logic [3:0]             avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  input  wire logic [3:0]             avs_byteenable,
  output logic [31:0]                 avs_readdata,
  output logic                        avs_waitrequest,
  input  wire logic [31:0]            ram_offset,
  output var  rampc_pkg::rampc_region_e data_ram_region,
  output logic                        ram_offset_valid,
  output logic [31:0]                 ram_kernel_program_base,
  output logic [31:0]                 ram_user_data_base,
  output logic [31:0]                 ram_user_program_base
);
  import rampc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait cycle, then the access completes.
  rampc_bus_e  bus_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic        accept;
  logic        wr_kpb;
  logic        wr_udb;
  logic        wr_upb;
  logic        full_word;
  logic [31:0] data_ram_size;
  logic [31:0] kpb_word;
  logic [31:0] udb_word;
  logic [31:0] upb_word;

  assign accept          = (bus_ff == rampc_done) && (avs_read || avs_write);
  assign avs_waitrequest = !accept;
  assign full_word       = avs_byteenable[1];
  assign wr_kpb = accept && avs_write && full_word && (avs_address == `RAMPC_OFS_KPB);
  assign wr_udb = accept && avs_write && full_word && (avs_address == `RAMPC_OFS_UDB);
  assign wr_upb = accept && avs_write && full_word && (avs_address == `RAMPC_OFS_UPB);
  assign data_ram_size = RAM_BYTES;

  always_ff @(posedge mclk) begin
    if (reset) begin
      bus_ff <= rampc_idle;
    end else begin
      case (bus_ff)
        rampc_idle: begin
          if (avs_read || avs_write) begin
            bus_ff <= rampc_done;
          end
        end
        rampc_done: begin
          bus_ff <= rampc_idle;
        end
        default: begin
          bus_ff <= rampc_idle;
        end
      endcase
    end
  end

  always_comb begin
    case (avs_address)
      `RAMPC_OFS_KPB:  nxt_rdata = kpb_word;
      `RAMPC_OFS_UDB:  nxt_rdata = udb_word;
      `RAMPC_OFS_UPB:  nxt_rdata = upb_word;
      `RAMPC_OFS_SIZE: nxt_rdata = data_ram_size;
      default:         nxt_rdata = `RAMPC_UNMAPPED_RD;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      rdata_ff <= 32'h00000000;
    end else if (avs_read && bus_ff == rampc_idle) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign avs_readdata = rdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Base registers.
  rampc_base_reg u_kpb (
    .mclk    (mclk),
    .reset   (reset),
    .wr_en   (wr_kpb),
    .wr_data (avs_writedata),
    .base_q  (),
    .rd_word (kpb_word)
  );

  rampc_base_reg u_udb (
    .mclk    (mclk),
    .reset   (reset),
    .wr_en   (wr_udb),
    .wr_data (avs_writedata),
    .base_q  (),
    .rd_word (udb_word)
  );

  rampc_base_reg u_upb (
    .mclk    (mclk),
    .reset   (reset),
    .wr_en   (wr_upb),
    .wr_data (avs_writedata),
    .base_q  (),
    .rd_word (upb_word)
  );

  assign ram_kernel_program_base = kpb_word;
  assign ram_user_data_base      = udb_word;
  assign ram_user_program_base   = upb_word;

  ////////////////////////////////////////////////////////////////////////////
  // Region lookup for a RAM offset.
  rampc_classify u_cls (
    .offset   (ram_offset),
    .kpb      (kpb_word),
    .udb      (udb_word),
    .upb      (upb_word),
    .ram_size (data_ram_size),
    .region   (data_ram_region),
    .in_range (ram_offset_valid)
  );
endmodule
`default_nettype wire

// ---- tb/ram_partition_config_bench.sv ----
// Self-checking bench of the RAM partition block.
`timescale 1ns/1ns
`default_nettype none
module ram_partition_config_bench;
  import rampc_pkg::*;
  localparam logic [31:0] SZ = 32'h00004000;
  logic          mclk = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [3:0]    avs_address = 4'h0, avs_byteenable = 4'h0;
  logic [31:0]   avs_writedata = 32'h0, ram_offset = 32'h0, avs_readdata, d;
  logic [31:0]   ram_kernel_program_base, ram_user_data_base, ram_user_program_base;
  logic          avs_waitrequest, ram_offset_valid;
  rampc_region_e data_ram_region;
  logic [31:0]   exp_q[$];
  int            error_cnt = 0, tests_run = 0, cyc = 0;
  rampc_top #(.RAM_BYTES(SZ)) dut (.*);
  always #4 mclk = ~mclk;
  task automatic wrap_up();
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] dt, input logic [3:0] be);
    @(posedge mclk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= dt;
    avs_byteenable <= be;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, $urandom, 4'hF);
  endtask
  task automatic at(input logic [31:0] o, input rampc_region_e r, input logic v);
    @(posedge mclk);
    ram_offset <= o;
    @(posedge mclk);
    cmp(data_ram_region, r);
    cmp(v, ram_offset_valid);
  endtask
  always @(posedge mclk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) cmp(avs_readdata, exp_q.pop_front());
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 4000) begin
      cmp(1'b0, 1'b1);
      wrap_up();
    end
  end
  initial begin
    void'($urandom(32'h5B5D));
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    for (int i = 0; i < 3; i++) rd(4'(4 * i), 32'h0);
    rd(4'hC, SZ);
    rd(4'h2, 32'h0);
    for (int i = 0; i < 12; i++) begin
      d = $urandom;
      bus(1'b1, 4'(4 * (i % 3)), d, 4'hF);
      rd(4'(4 * (i % 3)), d & 32'h0000FC00);
    end
    bus(1'b1, 4'h0, 32'h00001000, 4'hF);
    bus(1'b1, 4'h0, 32'hFFFFFFFF, 4'hD);
    rd(4'h0, 32'h00001000);
    bus(1'b1, 4'hC, 32'h0, 4'hF);
    rd(4'hC, SZ);
    bus(1'b1, 4'h4, 32'h00002000, 4'hF);
    bus(1'b1, 4'h4, 32'hFFFFFFFF, 4'hD);
    rd(4'h4, 32'h00002000);
    bus(1'b1, 4'h8, 32'h00003000, 4'hF);
    at(32'h00000FFF, rampc_kdata, 1'b1);
    at(32'h00001000, rampc_kprog, 1'b1);
    at(32'h00002000, rampc_udata, 1'b1);
    at(32'h00003FFF, rampc_uprog, 1'b1);
    at(32'h00004000, rampc_uprog, 1'b0);
    cmp(ram_user_data_base, 32'h00002000);
    cmp(ram_user_program_base, 32'h00003000);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    for (int i = 0; i < 3; i++) rd(4'(4 * i), 32'h0);
    @(posedge mclk);
    wrap_up();
  end
endmodule
`default_nettype wire

// ---- tb/rampc_props.sv ----
// Port checker of the RAM partition block.
`timescale 1ns/1ns
`default_nettype none
module rampc_props #(
  parameter logic [31:0] RAM_BYTES = 32'h00008000
) (
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [31:0] ram_offset,
  input wire logic        ram_offset_valid,
  input wire rampc_pkg::rampc_region_e data_ram_region,
  input wire logic [31:0] ram_kernel_program_base,
  input wire logic [31:0] ram_user_data_base,
  input wire logic [31:0] ram_user_program_base
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  chk_kpb_fixed_bits: assert property ((ram_kernel_program_base & 32'hFFFF03FF) == 32'h0)
    else $error("kpb fixed bits set");
  chk_user_fixed_bits: assert property (((ram_user_data_base | ram_user_program_base) & 32'hFFFF03FF) == 32'h0)
    else $error("user base fixed bits set");
  chk_reset_clears: assert property ($past(reset)
    |-> (ram_kernel_program_base | ram_user_data_base | ram_user_program_base) == 32'h0)
    else $error("base not cleared");
  chk_kprog_region: assert property (ram_kernel_program_base != 32'h0 && ram_offset >= ram_kernel_program_base
    && ram_offset < ram_user_data_base
    && (ram_user_program_base == 32'h0 || ram_offset < ram_user_program_base)
    |-> data_ram_region == rampc_pkg::rampc_kprog) else $error("kprog region wrong");
  chk_one_wait: assert property ($rose(avs_read | avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("wait cycle wrong");
  chk_kpb_write: assert property (avs_write && !avs_waitrequest && avs_address == 4'h0 && avs_byteenable[1]
    |=> ram_kernel_program_base == ($past(avs_writedata) & 32'h0000FC00)) else $error("kpb write lost");
  chk_udb_keep: assert property (avs_write && avs_address == 4'h4 && !avs_byteenable[1]
    |=> $stable(ram_user_data_base)) else $error("udb changed");
  chk_size_read: assert property (avs_read && !avs_waitrequest && avs_address == 4'hC |-> avs_readdata == RAM_BYTES)
    else $error("size wrong");
  chk_offset_valid: assert property (ram_offset_valid == (ram_offset < RAM_BYTES))
    else $error("valid wrong");
endmodule
bind rampc_top rampc_props #(.RAM_BYTES(RAM_BYTES)) props (.*);
`default_nettype wire
